// ==== hdl/gfr_fault_reporting.sv ====
`timescale 1ns/1ns

// Behaviour
// - Capture faulting address on protection check exception
// - Register access only from top exception level
// - Register absent without realm extension: undefined
// - Decode at encoding 3, 6, 6, 0, 5
// - Bits 63 and 62 give address space
// - Address bits 47:12; unimplemented bits read zero
// - Bits 51:48 only with large physical addressing
// - On table walk capture descriptor address
// - Captured fields have no reset value
// - Result bit 11 gives extension for top regime
// - Result non-secure bit for top, secure, realm
// - Walk protection fault status 100011 or 1001xx
// - Level -1 code needs wide granule extension
// - Buffer class 011110 for non-fault check errors
// - Buffer class equals syndrome class for checks
// - Buffer abort codes 100011, 1001xx, 101000
module gfr_fault_reporting #(
  parameter bit         HAS_REALM_EXT = 1'b1,
  parameter bit         HAS_LARGE_PA  = 1'b0,
  parameter bit         WIDE_GRANULE  = 1'b0,
  parameter int         PA_BITS       = gfr_pkg::PA_BITS_DEF,
  parameter logic [5:0] PB_EC_ABORT_S1 = 6'h24,
  parameter logic [5:0] PB_EC_ABORT_S2 = 6'h25
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  gfr_pkg::gfr_sysreg_req_t     sysreg_req,
  output gfr_pkg::gfr_sysreg_rsp_t     sysreg_rsp,
  input  gfr_pkg::gfr_gpc_fault_t      gpc_fault,
  input  gfr_pkg::gfr_xlate_t          xlate,
  output logic [63:0]                  translation_result_reg,
  input  gfr_pkg::gfr_pb_fault_t       pb_fault,
  output logic [63:0]                  profile_buffer_status_reg
);

  // Bits that hold storage in the fault address register
  function automatic logic [63:0] far_mask();
    logic [63:0] m;
    m = 64'h0;
    // Space bits always kept
    m[gfr_pkg::FAR_NS_BIT]  = 1'b1;
    m[gfr_pkg::FAR_NSE_BIT] = 1'b1;
    // Low field up to the implemented width
    for (int i = gfr_pkg::FPA_LO_LSB; i <= gfr_pkg::FPA_LO_MSB; i++) begin
      m[i] = (i < PA_BITS);
    end
    // High field also needs large addressing
    for (int i = gfr_pkg::FPA_HI_LSB; i <= gfr_pkg::FPA_HI_MSB; i++) begin
      m[i] = HAS_LARGE_PA && (i < PA_BITS);
    end
    return m;
  endfunction

  localparam logic [63:0] FAR_MASK = far_mask(); // Fixed by the build options

  // Fault address register storage, deliberately not reset
  logic [63:0]              fault_addr_reg;
  logic [63:0]              fault_addr_next;
  // Response and result registers
  gfr_pkg::gfr_sysreg_rsp_t rsp_reg;
  gfr_pkg::gfr_sysreg_rsp_t rsp_next;
  logic [63:0]              par_reg;
  logic [63:0]              par_next;
  logic [63:0]              pbs_reg;
  logic [63:0]              pbs_next;
  // Decode and capture terms
  logic                     far_hit;
  logic                     far_allowed;
  logic [51:0]              capture_pa;
  logic [63:0]              capture_word;
  logic [5:0]               xlate_gpf_fsc;
  logic [5:0]               pb_gpf_fsc;

  // Walk-level encoders for translation result and profiling buffer
  gfr_gpf_fsc_enc #(
    .WIDE_GRANULE (WIDE_GRANULE)
  ) u_xlate_fsc (
    .walk_level (xlate.walk_level),
    .fsc        (xlate_gpf_fsc)
  );

  gfr_gpf_fsc_enc #(
    .WIDE_GRANULE (WIDE_GRANULE)
  ) u_pb_fsc (
    .walk_level (pb_fault.walk_level),
    .fsc        (pb_gpf_fsc)
  );

  // Request decode; other encodings belong to other registers
  always_comb begin
    far_hit = sysreg_req.valid &&
              (sysreg_req.enc == {gfr_pkg::FAR_OP0, gfr_pkg::FAR_OP1, gfr_pkg::FAR_CRN,
                                  gfr_pkg::FAR_CRM, gfr_pkg::FAR_OP2});
    // Level and build gate
    far_allowed = HAS_REALM_EXT && (sysreg_req.el == gfr_pkg::EL_TOP);
  end

  // Build the captured word from the check's input address, or the descriptor address on a walk
  always_comb begin
    // Table walks report the descriptor fetch address
    capture_pa = gpc_fault.on_walk ? gpc_fault.desc_pa : gpc_fault.input_pa;
    capture_word = 64'h0;
    // Space pair into the top two bits
    capture_word[gfr_pkg::FAR_NS_BIT]  = gpc_fault.pas[0];
    capture_word[gfr_pkg::FAR_NSE_BIT] = gpc_fault.pas[1];
    // Address field spans both halves
    capture_word[gfr_pkg::FPA_HI_MSB:gfr_pkg::FPA_LO_LSB] =
      capture_pa[gfr_pkg::FPA_HI_MSB:gfr_pkg::FPA_LO_LSB];
    // Masking keeps unimplemented and reserved bits at zero
    capture_word = capture_word & FAR_MASK;
  end

  // Next value of the fault address register
  always_comb begin
    fault_addr_next = fault_addr_reg;
    if (HAS_REALM_EXT && gpc_fault.valid) begin
      // Hardware capture wins over a software write in the same cycle
      fault_addr_next = capture_word;
    end else if (far_hit && far_allowed && sysreg_req.write) begin
      fault_addr_next = sysreg_req.wdata & FAR_MASK;
    end
  end

  // No reset: software must not rely on the value before a capture
  always_ff @(posedge core_clk) begin
    fault_addr_reg <= fault_addr_next;
  end

  // Response to a decoded access, one cycle after the request
  always_comb begin
    rsp_next = '0;
    if (far_hit) begin
      rsp_next.valid = 1'b1;
      if (!far_allowed) begin
        // Lower levels and builds without the extension fault
        rsp_next.undef = 1'b1;
      end else if (!sysreg_req.write) begin
        // Reads return only kept bits
        rsp_next.rdata = fault_addr_reg & FAR_MASK;
      end
    end
  end

  // Translation result register update
  always_comb begin
    par_next = par_reg;
    if (xlate.valid) begin
      par_next = 64'h0;
      if (xlate.fault) begin
        // Fault: flag and status code only
        par_next[gfr_pkg::PAR_F_BIT] = 1'b1;
        if (xlate.gpf_walk && HAS_REALM_EXT) begin
          par_next[gfr_pkg::PAR_FST_LSB +: 6] = xlate_gpf_fsc;
        end else begin
          par_next[gfr_pkg::PAR_FST_LSB +: 6] = xlate.other_fst;
        end
      end else begin
        // Success: address and attributes
        par_next[gfr_pkg::FPA_HI_MSB:gfr_pkg::FPA_LO_LSB] = xlate.out_pa;
        // Unknown cases read zero rather than leaking stale attributes
        if (HAS_REALM_EXT && xlate.regime == gfr_pkg::GFR_REG_TOP) begin
          par_next[gfr_pkg::PAR_NSE_BIT] = xlate.nse_attr;
        end
        case (xlate.regime)
          gfr_pkg::GFR_REG_TOP: begin
            par_next[gfr_pkg::PAR_NS_BIT] = xlate.ns_attr;
          end
          gfr_pkg::GFR_REG_SECURE: begin
            par_next[gfr_pkg::PAR_NS_BIT] = xlate.ns_attr;
          end
          gfr_pkg::GFR_REG_REALM: begin
            // Realm EL1&0 stage 1 operations have no such attribute
            par_next[gfr_pkg::PAR_NS_BIT] = xlate.stage1_el10_op ? 1'b0 : xlate.ns_attr;
          end
          default: begin
            par_next[gfr_pkg::PAR_NS_BIT] = 1'b0;
          end
        endcase
      end
    end
  end

  // Profiling-buffer status register update
  always_comb begin
    pbs_next = pbs_reg;
    if (pb_fault.valid) begin
      pbs_next = 64'h0;
      case (pb_fault.kind)
        gfr_pkg::GFR_PB_GPC_OTHER: begin
          // Same class code as the exception syndrome; syndrome left zero
          pbs_next[gfr_pkg::PBS_EC_LSB +: 6] = gfr_pkg::EC_GPC;
        end
        gfr_pkg::GFR_PB_GPF_WALK: begin
          pbs_next[gfr_pkg::PBS_EC_LSB +: 6] = pb_fault.stage2 ? PB_EC_ABORT_S2 : PB_EC_ABORT_S1;
          // Code from the level encoder
          pbs_next[gfr_pkg::PBS_MSS_LSB +: 6] = pb_gpf_fsc;
        end
        gfr_pkg::GFR_PB_GPF_NOWALK: begin
          pbs_next[gfr_pkg::PBS_EC_LSB +: 6] = pb_fault.stage2 ? PB_EC_ABORT_S2 : PB_EC_ABORT_S1;
          // Fixed code off the walk
          pbs_next[gfr_pkg::PBS_MSS_LSB +: 6] = gfr_pkg::FSC_GPF_NOWALK;
        end
        default: begin
          pbs_next[gfr_pkg::PBS_EC_LSB +: 6] = pb_fault.stage2 ? PB_EC_ABORT_S2 : PB_EC_ABORT_S1;
          // Other aborts pass their code
          pbs_next[gfr_pkg::PBS_MSS_LSB +: 6] = pb_fault.other_fsc;
        end
      endcase
    end
  end

  // Registered state with synchronous reset
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // Address storage stays out of reset
      rsp_reg <= '0;
      par_reg <= gfr_pkg::REG_RESET;
      pbs_reg <= gfr_pkg::REG_RESET;
    end else begin
      rsp_reg <= rsp_next;
      par_reg <= par_next;
      pbs_reg <= pbs_next;
    end
  end

  // Outputs straight from flip-flops
  assign sysreg_rsp                = rsp_reg;
  assign translation_result_reg    = par_reg;
  assign profile_buffer_status_reg = pbs_reg;

  // Checks on the block's outputs and its address storage
  // Inputs only qualify them

  a_undef_low_el: assert property (@(posedge core_clk) disable iff (!reset_n)
    far_hit && (sysreg_req.el != 2'h3) |=> sysreg_rsp.valid && sysreg_rsp.undef)
    else $error("access below top level not undefined");

  a_undef_no_ext: assert property (@(posedge core_clk) disable iff (!reset_n)
    !HAS_REALM_EXT && sysreg_req.valid |=> !sysreg_rsp.valid || sysreg_rsp.undef)
    else $error("access without extension not undefined");

  a_decode_enc: assert property (@(posedge core_clk) disable iff (!reset_n)
    sysreg_rsp.valid |-> $past(sysreg_req.valid) &&
      ($past(sysreg_req.enc) == {2'h3, 3'h6, 4'h6, 4'h0, 3'h5}))
    else $error("response for a foreign encoding");

  a_capture_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    HAS_REALM_EXT && gpc_fault.valid ##1
      (far_hit && far_allowed && !sysreg_req.write && !gpc_fault.valid)
      |=> sysreg_rsp.rdata[47:12] == (($past(gpc_fault.on_walk, 2) ?
            $past(gpc_fault.desc_pa[47:12], 2) : $past(gpc_fault.input_pa[47:12], 2)) & FAR_MASK[47:12]))
    else $error("captured address not read back");

  a_walk_desc: assert property (@(posedge core_clk) disable iff (!reset_n)
    HAS_REALM_EXT && gpc_fault.valid && gpc_fault.on_walk
      |=> fault_addr_reg[51:12] == ($past(gpc_fault.desc_pa[51:12]) & FAR_MASK[51:12]))
    else $error("walk fault did not capture descriptor address");

  a_pas_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
    HAS_REALM_EXT && gpc_fault.valid |=> {fault_addr_reg[62], fault_addr_reg[63]} == $past(gpc_fault.pas))
    else $error("address space bits wrong");

  a_res0_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    sysreg_rsp.valid |-> (sysreg_rsp.rdata[61:52] == 10'h0) && (sysreg_rsp.rdata[11:0] == 12'h0))
    else $error("reserved bits not zero");

  a_hi_pa_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    !HAS_LARGE_PA && sysreg_rsp.valid |-> sysreg_rsp.rdata[51:48] == 4'h0)
    else $error("upper address bits set without large addressing");

  a_par_gpf_code: assert property (@(posedge core_clk) disable iff (!reset_n)
    HAS_REALM_EXT && xlate.valid && xlate.fault && xlate.gpf_walk && !xlate.walk_level.minus1
      |=> translation_result_reg[0] && (translation_result_reg[6:1] == {4'h9, $past(xlate.walk_level.level)}))
    else $error("walk protection fault code wrong");

  a_no_minus1: assert property (@(posedge core_clk) disable iff (!reset_n)
    !WIDE_GRANULE |-> (translation_result_reg[6:1] != 6'h23) && (profile_buffer_status_reg[5:0] != 6'h23))
    else $error("level -1 code without wide granule");

  a_par_nse: assert property (@(posedge core_clk) disable iff (!reset_n)
    xlate.valid && !xlate.fault |=> translation_result_reg[11] ==
      (HAS_REALM_EXT && ($past(xlate.regime) == gfr_pkg::GFR_REG_TOP) && $past(xlate.nse_attr)))
    else $error("extension attribute bit wrong");

  a_par_ns: assert property (@(posedge core_clk) disable iff (!reset_n)
    xlate.valid && !xlate.fault && (xlate.regime == gfr_pkg::GFR_REG_SECURE)
      |=> translation_result_reg[9] == $past(xlate.ns_attr))
    else $error("non-secure attribute bit wrong");

  a_pb_gpc_class: assert property (@(posedge core_clk) disable iff (!reset_n)
    pb_fault.valid && (pb_fault.kind == gfr_pkg::GFR_PB_GPC_OTHER)
      |=> (profile_buffer_status_reg[31:26] == 6'h1e) && (profile_buffer_status_reg[15:0] == 16'h0))
    else $error("buffer check class wrong");

  a_pb_nowalk: assert property (@(posedge core_clk) disable iff (!reset_n)
    pb_fault.valid && (pb_fault.kind == gfr_pkg::GFR_PB_GPF_NOWALK)
      |=> profile_buffer_status_reg[5:0] == 6'h28)
    else $error("buffer non-walk fault code wrong");

  a_pb_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    !pb_fault.valid |=> $stable(profile_buffer_status_reg))
    else $error("buffer status changed without event");

  // Plain faults keep the input address
  a_capture_input: assert property (@(posedge core_clk) disable iff (!reset_n)
    HAS_REALM_EXT && gpc_fault.valid && !gpc_fault.on_walk
      |=> fault_addr_reg[51:12] == ($past(gpc_fault.input_pa[51:12]) & FAR_MASK[51:12]))
    else $error("fault did not capture input address");

  // Refused access carries no data
  a_refused_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    sysreg_rsp.undef |-> sysreg_rsp.valid && (sysreg_rsp.rdata == 64'h0))
    else $error("refused access returned data");

  // Only kept bits read back
  a_unimpl_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    sysreg_rsp.valid |-> (sysreg_rsp.rdata & ~FAR_MASK) == 64'h0)
    else $error("unimplemented address bits set");

  // No extension: every hit refused
  a_no_ext_hit: assert property (@(posedge core_clk) disable iff (!reset_n)
    !HAS_REALM_EXT && far_hit |=> sysreg_rsp.valid && sysreg_rsp.undef)
    else $error("hit without extension not refused");

  // Fault flag follows the result
  a_par_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    xlate.valid |=> translation_result_reg[0] == $past(xlate.fault))
    else $error("translation fault flag wrong");

  // Level -1 code with wide granule
  a_par_minus1: assert property (@(posedge core_clk) disable iff (!reset_n)
    WIDE_GRANULE && HAS_REALM_EXT && xlate.valid && xlate.fault && xlate.gpf_walk && xlate.walk_level.minus1
      |=> translation_result_reg[6:1] == 6'h23)
    else $error("level -1 code missing");

  // Top regime non-secure attribute
  a_par_ns_top: assert property (@(posedge core_clk) disable iff (!reset_n)
    xlate.valid && !xlate.fault && (xlate.regime == gfr_pkg::GFR_REG_TOP)
      |=> translation_result_reg[9] == $past(xlate.ns_attr))
    else $error("top regime attribute wrong");

  // Buffer walk faults carry the level
  a_pb_walk_code: assert property (@(posedge core_clk) disable iff (!reset_n)
    pb_fault.valid && (pb_fault.kind == gfr_pkg::GFR_PB_GPF_WALK) && !pb_fault.walk_level.minus1
      |=> profile_buffer_status_reg[5:0] == {4'h9, $past(pb_fault.walk_level.level)})
    else $error("buffer walk fault code wrong");

endmodule

// ==== hdl/gfr_gpf_fsc_enc.sv ====
`timescale 1ns/1ns

// Fault status code for a protection fault met on a table walk
module gfr_gpf_fsc_enc #(
  parameter bit WIDE_GRANULE = 1'b0
) (
  input  gfr_pkg::gfr_walk_level_t walk_level,
  output logic [5:0]               fsc
);

  // Level -1 only exists with the wide granule; otherwise fold to level 0
  always_comb begin
    if (walk_level.minus1 && WIDE_GRANULE) begin
      fsc = gfr_pkg::FSC_GPF_LVL_M1;
    end else if (walk_level.minus1) begin
      fsc = {gfr_pkg::FSC_GPF_LVL_TOP, 2'h0};
    end else begin
      fsc = {gfr_pkg::FSC_GPF_LVL_TOP, walk_level.level};
    end
  end

endmodule

// ==== hdl/gfr_pkg.sv ====
package gfr_pkg;

  // System-register encoding of the fault address register
  localparam logic [1:0] FAR_OP0 = 2'h3;
  localparam logic [2:0] FAR_OP1 = 3'h6;
  localparam logic [3:0] FAR_CRN = 4'h6;
  localparam logic [3:0] FAR_CRM = 4'h0;
  localparam logic [2:0] FAR_OP2 = 3'h5;

  // Highest exception level
  localparam logic [1:0] EL_TOP = 2'h3;

  // Fault address register field positions
  localparam int FAR_NS_BIT  = 63;
  localparam int FAR_NSE_BIT = 62;
  localparam int FPA_HI_MSB  = 51;
  localparam int FPA_HI_LSB  = 48;
  localparam int FPA_LO_MSB  = 47;
  localparam int FPA_LO_LSB  = 12;
  localparam int PA_BITS_DEF = 48;

  // Translation result register field positions
  localparam int PAR_F_BIT   = 0;
  localparam int PAR_FST_LSB = 1;
  localparam int PAR_NS_BIT  = 9;
  localparam int PAR_NSE_BIT = 11;

  // Profiling-buffer status register field positions
  localparam int PBS_EC_LSB  = 26;
  localparam int PBS_MSS_LSB = 0;

  // Fault status and exception class codes
  localparam logic [5:0] FSC_GPF_LVL_M1  = 6'h23;
  localparam logic [3:0] FSC_GPF_LVL_TOP = 4'h9;
  localparam logic [5:0] FSC_GPF_NOWALK  = 6'h28;
  localparam logic [5:0] EC_GPC          = 6'h1e;

  // Reset value of the result and status registers
  localparam logic [63:0] REG_RESET = 64'h0;

  // Physical address space, coded {extension, non-secure}
  typedef enum logic [1:0] {
    GFR_PAS_SECURE    = 2'b00,
    GFR_PAS_NONSECURE = 2'b01,
    GFR_PAS_ROOT      = 2'b10,
    GFR_PAS_REALM     = 2'b11
  } gfr_pas_t;

  // Translation regime of a translate operation
  typedef enum logic [1:0] {
    GFR_REG_TOP       = 2'b00,
    GFR_REG_SECURE    = 2'b01,
    GFR_REG_NONSECURE = 2'b10,
    GFR_REG_REALM     = 2'b11
  } gfr_regime_t;

  // Kind of profiling-buffer write fault
  typedef enum logic [1:0] {
    GFR_PB_GPC_OTHER  = 2'b00,
    GFR_PB_GPF_WALK   = 2'b01,
    GFR_PB_GPF_NOWALK = 2'b10,
    GFR_PB_ABORT      = 2'b11
  } gfr_pb_kind_t;

  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } gfr_sysreg_enc_t;

  typedef struct packed {
    logic            valid;
    logic            write;
    gfr_sysreg_enc_t enc;
    logic [1:0]      el;
    logic [63:0]     wdata;
  } gfr_sysreg_req_t;

  typedef struct packed {
    logic        valid;
    logic        undef;
    logic [63:0] rdata;
  } gfr_sysreg_rsp_t;

  // Walk level: minus1 marks level -1, else level holds 0..3
  typedef struct packed {
    logic       minus1;
    logic [1:0] level;
  } gfr_walk_level_t;

  typedef struct packed {
    logic        valid;
    logic        on_walk;
    gfr_pas_t    pas;
    logic [51:0] input_pa;
    logic [51:0] desc_pa;
  } gfr_gpc_fault_t;

  typedef struct packed {
    logic            valid;
    logic            fault;
    logic            gpf_walk;
    gfr_walk_level_t walk_level;
    logic [5:0]      other_fst;
    gfr_regime_t     regime;
    logic            stage1_el10_op;
    logic            ns_attr;
    logic            nse_attr;
    logic [51:12]    out_pa;
  } gfr_xlate_t;

  typedef struct packed {
    logic            valid;
    gfr_pb_kind_t    kind;
    logic            stage2;
    gfr_walk_level_t walk_level;
    logic [5:0]      other_fsc;
  } gfr_pb_fault_t;

endpackage

// ==== verification/tb.sv ====
`timescale 1ns/1ns

module tb;
  // Feature sets per instance, bit g belongs to instance g
  localparam logic [2:0] REALM = 3'h3;  // Instance 2 lacks the realm extension
  localparam logic [2:0] LARGE = 3'h1;  // Only instance 0 keeps address bits 51:48
  localparam logic [2:0] WIDE  = 3'h1;  // Only instance 0 may report level -1
  localparam gfr_pkg::gfr_sysreg_enc_t ENC_HIT  = {gfr_pkg::FAR_OP0, gfr_pkg::FAR_OP1, gfr_pkg::FAR_CRN,
                                                   gfr_pkg::FAR_CRM, gfr_pkg::FAR_OP2};
  localparam gfr_pkg::gfr_sysreg_enc_t ENC_MISS = {gfr_pkg::FAR_OP0, gfr_pkg::FAR_OP1, gfr_pkg::FAR_CRN,
                                                   gfr_pkg::FAR_CRM, 3'h4};

  logic                     core_clk;     // Core clock
  logic                     reset_n;      // Synchronous reset
  gfr_pkg::gfr_sysreg_req_t sysreg_req;   // Shared register request
  gfr_pkg::gfr_gpc_fault_t  gpc_fault;    // Shared capture event
  gfr_pkg::gfr_xlate_t      xlate;        // Shared translate result
  gfr_pkg::gfr_pb_fault_t   pb_fault;     // Shared buffer fault
  gfr_pkg::gfr_sysreg_rsp_t rsp [3];      // Responses per instance
  logic [63:0]              tres [3];     // Translation results per instance
  logic [63:0]              pbs [3];      // Buffer status per instance
  logic [63:0]              stor [3];     // Expected stored address register
  int                       num_errors;   // Mismatches seen
  int                       checks_done;  // Comparisons made
  integer                   seed;         // Fixed seed keeps runs repeatable

  // Three feature sets see the same stimulus, so one run covers present and absent options
  for (genvar g = 0; g < 3; g++) begin : gen_dut
    gfr_fault_reporting #(.HAS_REALM_EXT(REALM[g]), .HAS_LARGE_PA(LARGE[g]), .WIDE_GRANULE(WIDE[g]),
                          .PA_BITS(g == 0 ? 52 : 44)) dut_u (
      .core_clk(core_clk), .reset_n(reset_n), .sysreg_req(sysreg_req), .sysreg_rsp(rsp[g]),
      .gpc_fault(gpc_fault), .xlate(xlate), .translation_result_reg(tres[g]), .pb_fault(pb_fault),
      .profile_buffer_status_reg(pbs[g]));
  end

  // Free-running core clock
  always #5 core_clk = ~core_clk;

  // Bits the address register keeps for instance g
  function automatic logic [63:0] mask(int g);
    logic [63:0] m;
    m = 64'hc000_0000_0000_0000;
    for (int i = 12; i < 52; i++) m[i] = (i < (g == 0 ? 52 : 44)) && (i < 48 || LARGE[g]);
    return m;
  endfunction

  // Status code of a protection fault met on a walk
  function automatic logic [5:0] walk_code(int g, gfr_pkg::gfr_walk_level_t wl);
    if (wl.minus1) return WIDE[g] ? gfr_pkg::FSC_GPF_LVL_M1 : {gfr_pkg::FSC_GPF_LVL_TOP, 2'h0};
    return {gfr_pkg::FSC_GPF_LVL_TOP, wl.level};
  endfunction

  // Expected translation result; unknown attributes read as zero
  function automatic logic [63:0] exp_tr(int g, gfr_pkg::gfr_xlate_t x);
    logic [63:0] r;
    r = 64'h0;
    if (x.fault) begin
      r[0] = 1'b1;
      r[6:1] = (x.gpf_walk && REALM[g]) ? walk_code(g, x.walk_level) : x.other_fst;
    end else begin
      r[51:12] = x.out_pa;
      r[11] = REALM[g] && (x.regime == gfr_pkg::GFR_REG_TOP) && x.nse_attr;
      r[9] = (x.regime != gfr_pkg::GFR_REG_NONSECURE) && x.ns_attr &&
             !(x.regime == gfr_pkg::GFR_REG_REALM && x.stage1_el10_op);
    end
    return r;
  endfunction

  // Expected buffer status
  function automatic logic [63:0] exp_pb(int g, gfr_pkg::gfr_pb_fault_t p);
    logic [63:0] r;
    r = 64'h0;
    if (p.kind == gfr_pkg::GFR_PB_GPC_OTHER) r[31:26] = gfr_pkg::EC_GPC;
    else begin
      r[31:26] = p.stage2 ? 6'h25 : 6'h24;
      r[5:0] = (p.kind == gfr_pkg::GFR_PB_GPF_WALK) ? walk_code(g, p.walk_level) :
               (p.kind == gfr_pkg::GFR_PB_GPF_NOWALK) ? gfr_pkg::FSC_GPF_NOWALK : p.other_fsc;
    end
    return r;
  endfunction

  // One comparison; case inequality keeps unknowns from matching
  task automatic cmp(string what, logic [65:0] exp, logic [65:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register access; the answer stands for the one cycle after the taking edge
  task automatic acc(logic [1:0] el, logic wr, logic [63:0] wd, bit hit);
    logic ok;
    @(posedge core_clk);
    sysreg_req <= {1'b1, wr, hit ? ENC_HIT : ENC_MISS, el, wd};
    @(posedge core_clk);
    sysreg_req.valid <= 1'b0;
    #1;
    for (int g = 0; g < 3; g++) begin
      ok = REALM[g] && el == gfr_pkg::EL_TOP;
      if (!hit) cmp("rsp_valid", 66'h0, {65'h0, rsp[g].valid});
      else if (!ok) cmp("refused", {2'h3, 64'h0}, rsp[g]);
      else if (wr) begin
        stor[g] = wd & mask(g);
        cmp("write_rsp", 66'h2, {64'h0, rsp[g].valid, rsp[g].undef});
      end else cmp("read", {2'h2, stor[g]}, rsp[g]);
    end
  endtask

  // Capture event, optionally with a write in the same cycle; the capture must win
  task automatic cap(logic walk, gfr_pkg::gfr_pas_t pas, logic [51:0] ipa, logic [51:0] dpa, bit with_wr,
                     logic [63:0] wd);
    @(posedge core_clk);
    gpc_fault <= {1'b1, walk, pas, ipa, dpa};
    if (with_wr) sysreg_req <= {1'b1, 1'b1, ENC_HIT, gfr_pkg::EL_TOP, wd};
    @(posedge core_clk);
    gpc_fault.valid <= 1'b0;
    // Read back at once unless a write raced the capture
    sysreg_req <= {!with_wr, 1'b0, ENC_HIT, gfr_pkg::EL_TOP, 64'h0};
    for (int g = 0; g < 3; g++) begin
      if (REALM[g]) stor[g] = {pas[0], pas[1], 10'h0, walk ? dpa[51:12] : ipa[51:12], 12'h0} & mask(g);
    end
    @(posedge core_clk);
    sysreg_req.valid <= 1'b0;
    #1;
    for (int g = 0; g < 3; g++) begin
      if (with_wr) cmp("race_idle", 66'h0, rsp[g]);
      else if (!REALM[g]) cmp("refused", {2'h3, 64'h0}, rsp[g]);
      else cmp("capture", {2'h2, stor[g]}, rsp[g]);
    end
  endtask

  // Translate result; looked at once it has settled
  task automatic xl(gfr_pkg::gfr_xlate_t x);
    x.valid = 1'b1;
    @(posedge core_clk);
    xlate <= x;
    @(posedge core_clk);
    xlate.valid <= 1'b0;
    @(posedge core_clk);
    #1;
    for (int g = 0; g < 3; g++) cmp("result", {2'h0, exp_tr(g, x)}, {2'h0, tres[g]});
  endtask

  // Buffer fault; status stands until the next fault
  task automatic pbt(gfr_pkg::gfr_pb_fault_t p);
    p.valid = 1'b1;
    @(posedge core_clk);
    pb_fault <= p;
    @(posedge core_clk);
    pb_fault.valid <= 1'b0;
    @(posedge core_clk);
    #1;
    for (int g = 0; g < 3; g++) cmp("status", {2'h0, exp_pb(g, p)}, {2'h0, pbs[g]});
  endtask

  // Single place where the run ends
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog sized well above the thousand or so cycles the tests take
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    gfr_pkg::gfr_xlate_t   x;
    gfr_pkg::gfr_pb_fault_t p;
    logic [63:0]           r;
    core_clk = 1'b0;
    reset_n = 1'b0;
    sysreg_req = '0;
    gpc_fault = '0;
    xlate = '0;
    pb_fault = '0;
    num_errors = 0;
    checks_done = 0;
    seed = 17;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    for (int g = 0; g < 3; g++) cmp("reset", 66'h0, {1'b0, rsp[g].valid, tres[g] | pbs[g]});
    acc(gfr_pkg::EL_TOP, 1'b1, 64'hffff_ffff_ffff_ffff, 1'b1);
    acc(gfr_pkg::EL_TOP, 1'b0, 64'h0, 1'b1);
    acc(2'h2, 1'b0, 64'h0, 1'b1);
    acc(2'h1, 1'b1, 64'h0, 1'b1);
    acc(gfr_pkg::EL_TOP, 1'b0, 64'h0, 1'b1);
    acc(gfr_pkg::EL_TOP, 1'b0, 64'h0, 1'b0);
    // Walk capture keeps the descriptor address, then a capture racing a write
    cap(1'b1, gfr_pkg::GFR_PAS_REALM, 52'h1_2345_6789_a000, 52'hf_edcb_a987_6000, 1'b0, 64'h0);
    acc(gfr_pkg::EL_TOP, 1'b0, 64'h0, 1'b1);
    cap(1'b0, gfr_pkg::GFR_PAS_ROOT, 52'ha_5a5a_5a5a_5000, 52'h0, 1'b1, 64'h0);
    acc(gfr_pkg::EL_TOP, 1'b0, 64'h0, 1'b1);
    // Every walk level including -1, in the result and the buffer status
    for (int i = 0; i < 5; i++) begin
      x = '0;
      x.fault = 1'b1;
      x.gpf_walk = 1'b1;
      x.walk_level = 3'(i);
      xl(x);
      p = '0;
      p.kind = gfr_pkg::GFR_PB_GPF_WALK;
      p.stage2 = i[0];
      p.walk_level = 3'(i);
      pbt(p);
    end
    // Every buffer fault kind
    for (int k = 0; k < 4; k++) begin
      p = '0;
      p.kind = gfr_pkg::gfr_pb_kind_t'(k[1:0]);
      p.stage2 = k[1];
      p.other_fsc = 6'h11;
      pbt(p);
    end
    // Every regime, with and without the stage 1 EL1&0 operation
    for (int k = 0; k < 8; k++) begin
      x = '0;
      x.regime = gfr_pkg::gfr_regime_t'(k[1:0]);
      x.stage1_el10_op = k[2];
      x.ns_attr = 1'b1;
      x.nse_attr = 1'b1;
      x.out_pa = 40'h00_1234_5678;
      xl(x);
    end
    // Random mix; translate addresses kept below bit 44 so all three instances agree
    for (int n = 0; n < 300; n++) begin
      r = {$random(seed), $random(seed)};
      case (r[63:62])
        2'h0: acc(r[61] ? gfr_pkg::EL_TOP : r[60:59], r[58], {$random(seed), $random(seed)}, r[57] | r[56]);
        2'h1: cap(r[61], gfr_pkg::gfr_pas_t'(r[60:59]), r[51:0], {r[25:0], r[51:26]}, r[58], r);
        2'h2: begin
          x = gfr_pkg::gfr_xlate_t'(r[$bits(gfr_pkg::gfr_xlate_t)-1:0]);
          x.out_pa[51:44] = 8'h0;
          // Level -1 code belongs to the walk encoder only
          if (x.other_fst == 6'h23) x.other_fst = 6'h22;
          xl(x);
        end
        default: begin
          p = gfr_pkg::gfr_pb_fault_t'(r[$bits(gfr_pkg::gfr_pb_fault_t)-1:0]);
          if (p.other_fsc == 6'h23) p.other_fsc = 6'h22;
          pbt(p);
        end
      endcase
    end
    report_and_stop;
  end
endmodule
